// File: shared/tws_params.svh
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// Register offsets of the device register space.
`define TWS_OFS_PORT_LO_FIRST 8'h02
`define TWS_OFS_PORT_LO_LAST  8'h05
`define TWS_OFS_PORT_HI_FIRST 8'h06
`define TWS_OFS_PORT_HI_LAST  8'h09
`define TWS_OFS_DEV_CFG       8'h27
`define TWS_OFS_GROUP_LO      8'h3C
`define TWS_OFS_GROUP_HI      8'h3D

// Number of byte locations held by the register memory.
`define TWS_REG_DEPTH         64

// Position of the timeout disable bit in the configuration register.
`define TWS_CFG_TMO_DIS_BIT   7

// Reset value of every stored register.
`define TWS_REG_RESET         8'h00

// Fixed upper five bits of the slave address.
`define TWS_SLAVE_ADDR_HI     5'h13

// Bus timeout in milliseconds and the clock rate in kHz.
`define TWS_TIMEOUT_MS        31
`define TWS_CLK_KHZ           125000

`endif

// File: shared/tws_pkg.sv
package tws_pkg;

    // Serial interface sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_CMD,
        ST_ACK_IN,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } tws_state_t;

endpackage

// File: shared/tws_reg_if.sv
// Write and read path between the serial engine and the register memory.
interface tws_reg_if;
    logic       wr_en;    // Single register write strobe.
    logic       grp_lo;   // Group write of the low port block.
    logic       grp_hi;   // Group write of the high port block.
    logic [7:0] wr_addr;  // Write address.
    logic [7:0] wr_data;  // Write data byte.
    logic [7:0] rd_addr;  // Read address.
    logic [7:0] rd_data;  // Registered read data.
    logic [7:0] cfg;      // Current device configuration byte.

    modport ctl (output wr_en, grp_lo, grp_hi, wr_addr, wr_data, rd_addr, input rd_data, cfg);
    modport mem (input wr_en, grp_lo, grp_hi, wr_addr, wr_data, rd_addr, output rd_data, cfg);
endinterface

// File: verilog/tws_regfile.sv
`include "tws_params.svh"

// Register memory with single and group writes and a registered read port.
module tws_regfile
    import tws_pkg::*;
(
    // Clock and reset.
    input  wire logic I_CLK,
    input  wire logic I_RST,
    // Register access path.
    tws_reg_if.mem    bus
);

    // All state of the memory.
    typedef struct packed {
        logic [`TWS_REG_DEPTH-1:0][7:0] mem;  // Stored register bytes.
        logic [7:0]                     rd;   // Registered read data.
    } tws_mem_t;

    tws_mem_t r;       // Current state.
    tws_mem_t next_r;  // Next state.

    // Per entry write select and read mux.
    always_comb begin
        next_r = r;
        for (int i = 0; i < `TWS_REG_DEPTH; i++) begin
            if (bus.grp_lo && (8'(i) >= `TWS_OFS_PORT_LO_FIRST) && (8'(i) <= `TWS_OFS_PORT_LO_LAST)) begin
                next_r.mem[i] = bus.wr_data;
            end else if (bus.grp_hi && (8'(i) >= `TWS_OFS_PORT_HI_FIRST) && (8'(i) <= `TWS_OFS_PORT_HI_LAST)) begin
                next_r.mem[i] = bus.wr_data;
            end else if (bus.wr_en && (bus.wr_addr == 8'(i))) begin
                next_r.mem[i] = bus.wr_data;
            end
        end
        // Pseudoregisters and locations beyond the 64-byte memory read as zero.
        if (bus.rd_addr < 8'(`TWS_REG_DEPTH)
            && bus.rd_addr != `TWS_OFS_GROUP_LO && bus.rd_addr != `TWS_OFS_GROUP_HI) begin
            next_r.rd = r.mem[bus.rd_addr[5:0]];
        end else begin
            next_r.rd = 8'h00;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            r <= '{default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign bus.rd_data = r.rd;
    assign bus.cfg     = r.mem[`TWS_OFS_DEV_CFG];

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    // A low group write lands in all four ports of the block.
    a_group_low_fill: assert property (bus.grp_lo |=>
        r.mem[2] == $past(bus.wr_data) && r.mem[3] == $past(bus.wr_data)
        && r.mem[4] == $past(bus.wr_data) && r.mem[5] == $past(bus.wr_data))
        else $error("low group write did not fill ports");

    // A high group write lands in all four ports of the block.
    a_group_high_fill: assert property (bus.grp_hi |=>
        r.mem[6] == $past(bus.wr_data) && r.mem[7] == $past(bus.wr_data)
        && r.mem[8] == $past(bus.wr_data) && r.mem[9] == $past(bus.wr_data))
        else $error("high group write did not fill ports");

    // A single write to one port leaves both of its neighbours untouched.
    a_single_port_only: assert property (bus.wr_en && bus.wr_addr == 8'h04
                                         |=> $stable(r.mem[3]) && $stable(r.mem[5]))
        else $error("single write changed a second port");

endmodule

// File: verilog/tws_top.sv
`include "tws_params.svh"

module tws_top
    import tws_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `TWS_TIMEOUT_MS * `TWS_CLK_KHZ  // Bus timeout in clock cycles.
)(
    // Clock and reset.
    input  wire logic       I_CLK,
    input  wire logic       I_RST,
    // Two-wire bus pins.
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    output logic            O_SDA_O,
    output logic            O_SDA_OE,
    // Address select and supply monitor.
    input  wire logic [1:0] I_ADDR_SEL,
    input  wire logic       I_SUPPLY_OK,
    // Port drive control.
    output logic [8:0]      O_PORT_HIZ
);

    localparam logic [21:0] TMO_LIM = 22'(TIMEOUT_CYCLES);  // Counter value at which the bus gives up.

    // All state of the serial engine.
    typedef struct packed {
        tws_state_t  st;     // Sequencer state.
        logic [3:0]  bits;   // Bits seen in the current byte.
        logic [7:0]  sh;     // Shift register.
        logic [7:0]  ptr;    // Register pointer.
        logic        rw;     // Direction of the current transfer.
        logic [21:0] tmo;    // Stall counter.
        logic        scl_q;  // Previous clock sample.
        logic        sda_q;  // Previous data sample.
        logic        oe;     // Data line pulled low.
        logic        sda_o;  // Data line output level.
        logic        wr;     // Single write strobe.
        logic        glo;    // Low group write strobe.
        logic        ghi;    // High group write strobe.
        logic [7:0]  waddr;  // Write address.
        logic [7:0]  wdata;  // Write data.
        logic [8:0]  hiz;    // Port high impedance forcing.
    } tws_core_t;

    tws_core_t r;       // Current state.
    tws_core_t next_r;  // Next state.

    tws_reg_if rif ();  // Path to the register memory.

    // Bus events decoded from the previous and current samples.
    logic scl_rise;  // Clock rising edge.
    logic scl_fall;  // Clock falling edge.
    logic start_ev;  // START or repeated START.
    logic stop_ev;   // STOP.
    logic tmo_en;    // Timeout function active.

    assign scl_rise = I_SCL && !r.scl_q;
    assign scl_fall = !I_SCL && r.scl_q;
    assign start_ev = I_SCL && r.scl_q && r.sda_q && !I_SDA;
    assign stop_ev  = I_SCL && r.scl_q && !r.sda_q && I_SDA;
    assign tmo_en   = !rif.cfg[`TWS_CFG_TMO_DIS_BIT];

    // Serial engine next state.
    always_comb begin
        next_r       = r;
        next_r.scl_q = I_SCL;
        next_r.sda_q = I_SDA;
        next_r.sda_o = 1'b0;
        next_r.wr    = 1'b0;
        next_r.glo   = 1'b0;
        next_r.ghi   = 1'b0;
        // Ports float whenever the core supply is missing.
        next_r.hiz   = I_SUPPLY_OK ? 9'h000 : 9'h1FF;
        // The counter only runs while a transfer stalls between clock edges.
        if (r.st == ST_IDLE || stop_ev || scl_rise || scl_fall || !tmo_en) begin
            next_r.tmo = 22'h00_0000;
        end else begin
            next_r.tmo = r.tmo + 22'h00_0001;
        end
        if (!I_SUPPLY_OK) begin
            // No supply: interface is held idle and lets go of the line.
            next_r.st = ST_IDLE;
            next_r.oe = 1'b0;
        end else if (start_ev) begin
            // A repeated START keeps the pointer, so a read can follow its setup write.
            next_r.st   = ST_ADDR;
            next_r.bits = 4'h0;
            next_r.oe   = 1'b0;
        end else if (stop_ev) begin
            // STOP ends the transfer and frees the line.
            next_r.st = ST_IDLE;
            next_r.oe = 1'b0;
        end else if (tmo_en && r.tmo >= TMO_LIM) begin
            // A stall gives up the transfer and waits for a new START.
            next_r.st = ST_IDLE;
            next_r.oe = 1'b0;
        end else begin
            case (r.st)
                ST_IDLE: begin
                    // Everything but START is ignored here.
                    next_r.st = ST_IDLE;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise) begin
                        next_r.sh   = {r.sh[6:0], I_SDA};
                        next_r.bits = r.bits + 4'h1;
                    end else if (scl_fall && r.bits == 4'h8) begin
                        next_r.bits = 4'h0;
                        if (r.st == ST_ADDR) begin
                            // Acknowledge only our own address.
                            if (r.sh[7:1] == {`TWS_SLAVE_ADDR_HI, I_ADDR_SEL}) begin
                                next_r.rw = r.sh[0];
                                next_r.oe = 1'b1;
                                next_r.st = ST_ACK_ADDR;
                            end else begin
                                next_r.st = ST_IDLE;
                            end
                        end else if (r.st == ST_CMD) begin
                            // Command byte becomes the register pointer.
                            next_r.ptr = r.sh;
                            next_r.oe  = 1'b1;
                            next_r.st  = ST_ACK_IN;
                        end else begin
                            // Data byte: group pseudoregisters or one single register.
                            next_r.waddr = r.ptr;
                            next_r.wdata = r.sh;
                            if (r.ptr == `TWS_OFS_GROUP_LO) begin
                                next_r.glo = 1'b1;
                            end else if (r.ptr == `TWS_OFS_GROUP_HI) begin
                                next_r.ghi = 1'b1;
                            end else begin
                                next_r.wr = 1'b1;
                            end
                            next_r.ptr = r.ptr + 8'h01;
                            next_r.oe  = 1'b1;
                            next_r.st  = ST_ACK_IN;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        next_r.bits = 4'h0;
                        if (r.rw) begin
                            // Load the first read byte and drive its top bit.
                            next_r.sh  = rif.rd_data;
                            next_r.ptr = r.ptr + 8'h01;
                            next_r.oe  = !rif.rd_data[7];
                            next_r.st  = ST_RDATA;
                        end else begin
                            next_r.oe = 1'b0;
                            next_r.st = ST_CMD;
                        end
                    end
                end
                ST_ACK_IN: begin
                    // End of acknowledge: further bytes are data.
                    if (scl_fall) begin
                        next_r.oe   = 1'b0;
                        next_r.bits = 4'h0;
                        next_r.st   = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_r.bits = r.bits + 4'h1;
                    end else if (scl_fall) begin
                        if (r.bits == 4'h8) begin
                            next_r.oe   = 1'b0;
                            next_r.bits = 4'h0;
                            next_r.st   = ST_RACK;
                        end else begin
                            next_r.sh = {r.sh[6:0], 1'b0};
                            next_r.oe = !r.sh[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        // Master NACK ends the read; ACK asks for another byte.
                        if (I_SDA) begin
                            next_r.st = ST_IDLE;
                        end else begin
                            next_r.bits = 4'h1;
                        end
                    end else if (scl_fall && r.bits == 4'h1) begin
                        next_r.sh   = rif.rd_data;
                        next_r.ptr  = r.ptr + 8'h01;
                        next_r.oe   = !rif.rd_data[7];
                        next_r.bits = 4'h0;
                        next_r.st   = ST_RDATA;
                    end
                end
                default: begin
                    next_r.st = ST_IDLE;
                end
            endcase
        end
    end

    // State register with synchronous reset; ports float during reset.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            r       <= '0;
            r.st    <= ST_IDLE;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.hiz   <= 9'h1FF;
        end else begin
            r <= next_r;
        end
    end

    // Register memory hookup.
    assign rif.wr_en   = r.wr;
    assign rif.grp_lo  = r.glo;
    assign rif.grp_hi  = r.ghi;
    assign rif.wr_addr = r.waddr;
    assign rif.wr_data = r.wdata;
    assign rif.rd_addr = r.ptr;

    tws_regfile u_regs (
        .I_CLK (I_CLK),
        .I_RST (I_RST),
        .bus   (rif)
    );

    // Outputs straight from flip-flops.
    assign O_SDA_O    = r.sda_o;
    assign O_SDA_OE   = r.oe;
    assign O_PORT_HIZ = r.hiz;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence s_stall_at_limit;
        I_SUPPLY_OK && !start_ev && !stop_ev && tmo_en && r.tmo >= TMO_LIM;
    endsequence

    sequence s_released_idle;
        r.st == ST_IDLE && !O_SDA_OE;
    endsequence

    // Stall at the limit gives up and releases the data line.
    a_timeout_release: assert property (s_stall_at_limit |=> s_released_idle)
        else $error("timeout did not release the bus");

    // With timeout disabled the counter never leaves zero.
    a_timeout_disabled: assert property (!tmo_en |=> r.tmo == 22'h00_0000)
        else $error("timeout counter ran while disabled");

    // A busy bus with no clock edge keeps counting.
    a_stall_counts: assert property (r.st != ST_IDLE && tmo_en && !scl_rise && !scl_fall && !stop_ev
                                     |=> r.tmo == $past(r.tmo) + 22'h00_0001)
        else $error("stall counter did not advance");

    // Idle or STOP clears the counter.
    a_idle_clears: assert property ((r.st == ST_IDLE || stop_ev) |=> r.tmo == 22'h00_0000)
        else $error("stall counter not cleared");

    // Idle stays idle until a START arrives.
    a_wait_start: assert property (r.st == ST_IDLE && !start_ev |=> r.st == ST_IDLE)
        else $error("left idle without START");

    // Data writes are one of single, low group or high group.
    a_one_write_kind: assert property ($onehot0({r.wr, r.glo, r.ghi}))
        else $error("write strobes overlap");

    // Supply loss for two cycles floats all ports in the next cycle.
    a_supply_hiz: assert property (!I_SUPPLY_OK ##1 !I_SUPPLY_OK |=> O_PORT_HIZ == 9'h1FF [*1])
        else $error("ports driven without supply");

    // Each data write advances the pointer by one.
    a_ptr_advance: assert property ($rose(r.wr) |-> r.ptr == r.waddr + 8'h01)
        else $error("pointer did not advance after write");

endmodule

// File: verification/tws_bus_master.sv
// Behavioural bus master that drives the clock line and pulls the data line low.
module tws_bus_master (
    // Clock and the resolved data wire.
    input  wire logic i_clk,
    input  wire logic i_sda,
    // Clock line level and data pull-down enable.
    output logic      o_scl,
    output logic      o_sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    int half = 5;  // Clock half period in system clocks, slowed by the bench for the slow clock test.

    // The bus rests with both lines released high.
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // Waits n clocks and then steps just past the edge, so lines never move on it.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Holds the clock line at one level for n clocks.
    task automatic hold(input logic level, input int n);
        o_scl = level;
        tick(n);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        o_sda_oe = 1'b0;
        tick(half);
        o_scl = 1'b1;
        tick(half);
        o_sda_oe = 1'b1;
        tick(half);
        o_scl = 1'b0;
        tick(1);
    endtask

    // Stop: data rises while the clock is high, then the bus is left idle.
    task automatic stop();
        o_sda_oe = 1'b1;
        tick(half);
        o_scl = 1'b1;
        tick(half);
        o_sda_oe = 1'b0;
        tick(half);
    endtask

    // One clock pulse: data is set while the clock is low and sampled while it is high.
    task automatic xfer_bit(input logic b, output logic r);
        o_sda_oe = !b;
        tick(half);
        o_scl = 1'b1;
        tick(half);
        r = i_sda;
        o_scl = 1'b0;
        tick(1);
    endtask

    // Sends one byte most significant bit first and returns the acknowledge.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = !r;
    endtask

    // Receives one byte and answers with an acknowledge or, on the last byte, a refusal.
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(nack, r);
    endtask
endmodule

// File: verification/tb.sv
`include "tws_params.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin error_cnt++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (act), (exp)); end end

// Self-checking bench for the serial slave with timeout and group writes.
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int         TMO   = 200;                               // Shortened bus timeout.
    localparam logic [1:0] SEL   = 2'b10;                             // Address select pins.
    localparam logic [7:0] DEV_W = {`TWS_SLAVE_ADDR_HI, SEL, 1'b0};   // Write address byte.

    // One table row: command, data byte and how many port bytes should change.
    typedef struct {
        logic [7:0] cmd;
        logic [7:0] data;
        logic [3:0] nchg;
    } tws_row_t;

    tws_row_t   rows [6] = '{'{8'h3C, 8'hA5, 4'h4}, '{8'h04, 8'h5A, 4'h1}, '{8'h3D, 8'h3C, 4'h4},
                             '{8'h09, 8'h81, 4'h1}, '{8'h3C, 8'h00, 4'h4}, '{8'h07, 8'hFF, 4'h1}};
    logic       clk;         // System clock.
    logic       rst;         // Synchronous reset.
    logic       supply_ok;   // Core supply good.
    logic       scl;         // Clock line from the master.
    logic       m_oe;        // Master pull-down.
    logic       sda_o;       // Device data level.
    logic       sda_oe;      // Device pull-down.
    logic [8:0] port_hiz;    // Port high impedance flags.
    logic [7:0] shadow [64]; // Expected register contents.
    int         error_cnt;   // Mismatches seen.
    int         checked;     // Comparisons made.
    wire        sda_wire = !(sda_oe | m_oe);  // Open-drain wire with pull-up.

    // Clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    tws_top #(.TIMEOUT_CYCLES(TMO)) DUT (.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_wire),
        .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .I_ADDR_SEL(SEL), .I_SUPPLY_OK(supply_ok), .O_PORT_HIZ(port_hiz));

    tws_bus_master mst (.i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_oe(m_oe));

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reports the end of one test.
    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, error_cnt);
    endtask

    // Writes a run of bytes from a pointer; ok is high when every byte was acknowledged.
    task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d [$], output logic ok);
        logic a;
        mst.start();
        mst.wr_byte(DEV_W, ok);
        mst.wr_byte(ptr, a);
        ok &= a;
        foreach (d[i]) begin
            mst.wr_byte(d[i], a);
            ok &= a;
        end
        mst.stop();
    endtask

    // Sets the pointer, then reads n bytes after a repeated start so no one moves it between.
    task automatic reg_rd(input logic [7:0] ptr, input int n, output logic [7:0] q [$]);
        logic       a;
        logic [7:0] b;
        q = {};
        mst.start();
        mst.wr_byte(DEV_W, a);
        mst.wr_byte(ptr, a);
        mst.start();
        mst.wr_byte(DEV_W | 8'h01, a);
        for (int i = 0; i < n; i++) begin
            mst.rd_byte(i == n - 1, b);
            q.push_back(b);
        end
        mst.stop();
    endtask

    // Stalls the clock at one level during the address acknowledge and checks the recovery.
    task automatic stall_case(input logic level, input logic tmo_on);
        logic a;
        mst.start();
        for (int i = 7; i >= 0; i--) begin
            mst.xfer_bit(DEV_W[i], a);
        end
        mst.hold(level, TMO + 20);
        `CHK(sda_oe, !tmo_on)
        if (level) begin
            mst.hold(1'b0, 2);
        end else if (!tmo_on) begin
            mst.xfer_bit(1'b1, a);
        end
        if (tmo_on) begin
            mst.wr_byte(DEV_W, a);
            `CHK(a, 1'b0)
        end
        mst.stop();
        reg_wr(8'h10, {8'h00}, a);
        `CHK(a, 1'b1)
    endtask

    // Watchdog sized well above the expected run length.
    initial begin
        #(60_000 * 8);
        error_cnt++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        logic       ok;
        logic [7:0] q [$];
        logic [7:0] prev [$];
        logic [3:0] cnt;
        error_cnt = 0;
        checked = 0;
        rst = 1'b1;
        supply_ok = 1'b1;
        foreach (shadow[i]) shadow[i] = `TWS_REG_RESET;
        repeat (20) @(posedge clk);
        #1;
        `CHK(port_hiz, 9'h1FF)
        `CHK(sda_oe, 1'b0)
        rst = 1'b0;
        mst.tick(3);
        `CHK(port_hiz, 9'h000)
        `CHK(sda_o, 1'b0)
        reg_rd(`TWS_OFS_DEV_CFG, 1, q);
        `CHK(q[0], `TWS_REG_RESET)
        reg_rd(8'h02, 8, prev);
        test_end("reset");
        // Table of single and group writes, each followed by a readback of all eight ports.
        foreach (rows[r]) begin
            reg_wr(rows[r].cmd, {rows[r].data}, ok);
            `CHK(ok, 1'b1)
            if (rows[r].cmd == `TWS_OFS_GROUP_LO) begin
                for (int i = 2; i <= 5; i++) shadow[i] = rows[r].data;
            end else if (rows[r].cmd == `TWS_OFS_GROUP_HI) begin
                for (int i = 6; i <= 9; i++) shadow[i] = rows[r].data;
            end else begin
                shadow[rows[r].cmd[5:0]] = rows[r].data;
            end
            reg_rd(8'h02, 8, q);
            cnt = 4'h0;
            for (int i = 0; i < 8; i++) begin
                `CHK(q[i], shadow[i + 2])
                if (q[i] !== prev[i]) cnt++;
            end
            `CHK(cnt, rows[r].nchg)
            prev = q;
        end
        test_end("table");
        // Multi-byte write across the port boundary; the pointer advances per byte.
        reg_wr(8'h08, {8'h11, 8'h22, 8'h33}, ok);
        reg_rd(8'h08, 4, q);
        `CHK(q[0], 8'h11)
        `CHK(q[1], 8'h22)
        `CHK(q[2], 8'h33)
        `CHK(q[3], 8'h00)
        reg_rd(`TWS_OFS_GROUP_LO, 1, q);
        `CHK(q[0], 8'h00)
        test_end("pointer");
        // Wrong address is ignored.
        mst.start();
        mst.wr_byte(DEV_W ^ 8'h04, ok);
        `CHK(ok, 1'b0)
        mst.stop();
        test_end("address");
        // Stalls with timeout on, then with it off through the configuration bit.
        stall_case(1'b0, 1'b1);
        stall_case(1'b1, 1'b1);
        reg_wr(`TWS_OFS_DEV_CFG, {8'h80}, ok);
        reg_rd(`TWS_OFS_DEV_CFG, 1, q);
        `CHK(q[0], 8'h80)
        stall_case(1'b0, 1'b0);
        stall_case(1'b1, 1'b0);
        reg_wr(`TWS_OFS_DEV_CFG, {8'h00}, ok);
        test_end("timeout");
        // Slow but steady clock and a long idle must not trip the timeout.
        mst.tick(2 * TMO);
        mst.half = TMO - 40;
        reg_wr(8'h05, {8'h3E}, ok);
        mst.half = 5;
        `CHK(ok, 1'b1)
        test_end("slow");
        // Supply loss floats every port and silences the interface.
        supply_ok = 1'b0;
        mst.tick(2);
        `CHK(port_hiz, 9'h1FF)
        mst.start();
        mst.wr_byte(DEV_W, ok);
        `CHK(ok, 1'b0)
        mst.stop();
        supply_ok = 1'b1;
        mst.tick(2);
        `CHK(port_hiz, 9'h000)
        test_end("supply");
        print_verdict();
    end
endmodule
